// *** pkg/sai_params.svh ***
// Constants for the ship alarm input conditioner.
`ifndef SAI_PARAMS_SVH
`define SAI_PARAMS_SVH

// ****************************************
// Input count and timing
// ****************************************
`define SAI_NUM_IN 11
`define SAI_CLK_HZ 250000000
`define SAI_TICK_S 1
`define SAI_BAUD 9600
`define SAI_DLY_MAX 7'h63

// ****************************************
// Register offsets, byte addresses
// ****************************************
`define SAI_OFS_CFG0 8'h00
`define SAI_OFS_CFG_END 8'h2C
`define SAI_OFS_STATE 8'h40
`define SAI_OFS_IRQ_STAT 8'h44
`define SAI_OFS_IRQ_MASK 8'h48
`define SAI_OFS_CTRL 8'h4C
`define SAI_OFS_LANG 8'h50
`define SAI_OFS_TSEL 8'h54
`define SAI_OFS_TXT 8'h58

// ****************************************
// Field positions and reset values
// ****************************************
`define SAI_ST_PROG_BIT 16
`define SAI_ST_ENG_BIT 17
`define SAI_CTRL_PROG_BIT 0
`define SAI_TSEL_IDX_LSB 8
`define SAI_IRQ_CFG_BIT 11
`define SAI_CFG_RST 21'h000183
`define SAI_MASK_RST 12'h000
`define SAI_LANG_RST 3'h0

// ****************************************
// Serial commands and text store
// ****************************************
`define SAI_CMD_WR 8'h57
`define SAI_CMD_TXT 8'h54
`define SAI_CMD_RD 8'h52
`define SAI_NUM_LANG 3'h5
`define SAI_TXT_LEN 5'h15
`define SAI_TXT_WORDS 1155

`endif

// *** pkg/sai_pkg.sv ***
// Types shared by the ship alarm input conditioner.
`default_nettype none
package sai_pkg;

   // One stored configuration set per input.
   typedef struct packed {
      logic display;
      logic nc;
      logic still;
      logic [3:0] block;
      logic [6:0] off_dly;
      logic [6:0] on_dly;
   } sai_cfg_t;

   typedef enum logic [3:0] {
      P_IDLE, P_WIDX, P_WON, P_WOFF, P_WFLG,
      P_TIDX, P_TLANG, P_TPOS, P_TCHR, P_READ
   } sai_pst_t;

   typedef enum logic [1:0] {
      R_IDLE, R_START, R_DATA, R_STOP
   } sai_rst_t;

endpackage
`default_nettype wire

// *** src/sai_cond.sv ***
// Debounce of one alarm contact with separate ON and OFF delays.
`default_nettype none
module sai_cond (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic raw_act,
   input wire logic [6:0] on_dly,
   input wire logic [6:0] off_dly,
   output logic act
);
   logic act_q, act_d;
   logic [6:0] cnt_q, cnt_d;
   logic [6:0] lim;

   // The count runs on the shared tick, so a delay of N seconds
   // lasts between N-1 and N seconds of contact time.
   always_comb begin
      act_d = act_q;
      cnt_d = cnt_q;
      lim = act_q ? off_dly : on_dly;
      if (raw_act == act_q) begin
         cnt_d = 7'h00; // RL15
      end else if (cnt_q >= lim) begin
         act_d = raw_act; // RL3 RL4
         cnt_d = 7'h00;
      end else if (tick) begin
         cnt_d = cnt_q + 7'h01; // RL15
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         act_q <= 1'b0;
         cnt_q <= 7'h00;
      end else begin
         act_q <= act_d;
         cnt_q <= cnt_d;
      end
   end

   assign act = act_q;
endmodule
`default_nettype wire

// *** src/sai_top.sv ***
// Ship alarm input conditioner with register port and serial link.
// Notes on behaviour
// RL1: Eleven contact inputs each have their own settings and outputs.
// RL2: A per-input bit routes the state to alarm or to indication.
// RL3: An input goes active after its ON delay of 0 to 99 s unbroken.
// RL4: An input goes inactive after its OFF delay of 0 to 99 s unbroken.
// RL5: Polarity selects active-open (NC) or active-closed (NO).
// RL6: An input is suppressed while its named source input is active.
// RL7: A source index of zero means no suppression by another input.
// RL8: An option suppresses the input while the engine stands still.
// RL9: Reset gives alarm role, NO, no suppression, 3 s delays.
// RL10: Texts of 21 characters in 5 languages; the selected one is used.
// RL11: Serial configuration is taken only in programming mode.
// RL12: The PC can read back the whole input configuration.
// RL13: Configuration travels over an asynchronous RS-232 serial line.
// RL14: Programming mode lasts until software leaves it on escape.
// RL15: A one-second tick times the delays; a reversal restarts them.
// RL16: A source index naming itself or above eleven means no source.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "sai_params.svh"
`default_nettype none
module sai_top
   import sai_pkg::*;
#(
   parameter int unsigned TICK_CYC = `SAI_CLK_HZ * `SAI_TICK_S,
   parameter int unsigned BIT_CYC = `SAI_CLK_HZ / `SAI_BAUD
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [10:0] contact,
   input wire logic engine_run,
   input wire logic rxd,
   output logic txd,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [10:0] alarm,
   output logic [10:0] indication,
   output logic irq
);
   localparam int N = `SAI_NUM_IN;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [10:0] con_s1_q, con_s2_q;
   logic eng_s1_q, eng_s2_q, rx_s1_q, rx_s2_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         con_s1_q <= 11'h000;
         con_s2_q <= 11'h000;
         eng_s1_q <= 1'b0;
         eng_s2_q <= 1'b0;
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         con_s1_q <= contact;
         con_s2_q <= con_s1_q;
         eng_s1_q <= engine_run;
         eng_s2_q <= eng_s1_q;
         rx_s1_q <= rxd;
         rx_s2_q <= rx_s1_q;
      end
   end

   // ****************************************
   // One-second tick
   // ****************************************
   logic [27:0] tk_q, tk_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = (tk_q == 28'(TICK_CYC - 1)); // RL15
      tk_d = tick_d ? 28'h0000000 : tk_q + 28'h0000001;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tk_q <= 28'h0000000;
         tick_q <= 1'b0;
      end else begin
         tk_q <= tk_d;
         tick_q <= tick_d;
      end
   end

   // ****************************************
   // Per-input conditioning
   // ****************************************
   sai_cfg_t cfg_q [N];
   sai_cfg_t cfg_d [N];
   logic [10:0] raw_act, act, blk_ok, blocked, still_sup;
   logic [10:0] alarm_d, ind_d, alarm_q, ind_q;

   for (genvar g = 0; g < N; g++) begin : g_in
      // A high contact level means the contact is closed.
      assign raw_act[g] = cfg_q[g].nc ? ~con_s2_q[g] : con_s2_q[g]; // RL5
      sai_cond u_cond (
         .clk(clk),
         .resetn(resetn),
         .tick(tick_q),
         .raw_act(raw_act[g]),
         .on_dly(cfg_q[g].on_dly),
         .off_dly(cfg_q[g].off_dly),
         .act(act[g])
      ); // RL1
      assign blk_ok[g] = (cfg_q[g].block != 4'h0) && // RL7
         (cfg_q[g].block <= 4'hB) && // RL16
         (cfg_q[g].block != 4'(g + 1)); // RL16
      assign blocked[g] = blk_ok[g] && act[cfg_q[g].block - 4'h1]; // RL6
      assign still_sup[g] = cfg_q[g].still & ~eng_s2_q; // RL8
      assign alarm_d[g] = act[g] & ~cfg_q[g].display & // RL2
         ~blocked[g] & ~still_sup[g];
      assign ind_d[g] = act[g] & cfg_q[g].display & // RL2
         ~blocked[g] & ~still_sup[g];
   end

   // ****************************************
   // Serial receiver
   // ****************************************
   sai_rst_t rs_q, rs_d;
   logic [15:0] rbc_q, rbc_d;
   logic [2:0] rnb_q, rnb_d;
   logic [7:0] rsh_q, rsh_d;
   logic rvld_q, rvld_d;

   always_comb begin
      rs_d = rs_q;
      rbc_d = rbc_q;
      rnb_d = rnb_q;
      rsh_d = rsh_q;
      rvld_d = 1'b0;
      case (rs_q) // RL13
         R_IDLE: begin
            if (!rx_s2_q) begin
               rs_d = R_START;
               rbc_d = 16'(BIT_CYC / 2);
            end
         end
         R_START: begin
            if (rbc_q != 16'h0000) begin
               rbc_d = rbc_q - 16'h0001;
            end else if (!rx_s2_q) begin
               rs_d = R_DATA;
               rbc_d = 16'(BIT_CYC - 1);
               rnb_d = 3'h0;
            end else begin
               rs_d = R_IDLE;
            end
         end
         R_DATA: begin
            if (rbc_q != 16'h0000) begin
               rbc_d = rbc_q - 16'h0001;
            end else begin
               rsh_d = {rx_s2_q, rsh_q[7:1]};
               rbc_d = 16'(BIT_CYC - 1);
               rnb_d = rnb_q + 3'h1;
               if (rnb_q == 3'h7) begin
                  rs_d = R_STOP;
               end
            end
         end
         R_STOP: begin
            if (rbc_q != 16'h0000) begin
               rbc_d = rbc_q - 16'h0001;
            end else begin
               // A byte with a broken stop bit is dropped.
               rvld_d = rx_s2_q;
               rs_d = R_IDLE;
            end
         end
         default: rs_d = R_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rs_q <= R_IDLE;
         rbc_q <= 16'h0000;
         rnb_q <= 3'h0;
         rsh_q <= 8'h00;
         rvld_q <= 1'b0;
      end else begin
         rs_q <= rs_d;
         rbc_q <= rbc_d;
         rnb_q <= rnb_d;
         rsh_q <= rsh_d;
         rvld_q <= rvld_d;
      end
   end

   // ****************************************
   // Serial transmitter
   // ****************************************
   logic [9:0] tsh_q, tsh_d;
   logic [3:0] tnb_q, tnb_d;
   logic [15:0] tbc_q, tbc_d;
   logic tload;
   logic [7:0] tbyte;

   // The shifter idles at all ones, so its low bit is the line level.
   always_comb begin
      tsh_d = tsh_q;
      tnb_d = tnb_q;
      tbc_d = tbc_q;
      if (tload) begin
         tsh_d = {1'b1, tbyte, 1'b0}; // RL13
         tnb_d = 4'hA;
         tbc_d = 16'(BIT_CYC - 1);
      end else if (tnb_q != 4'h0) begin
         if (tbc_q != 16'h0000) begin
            tbc_d = tbc_q - 16'h0001;
         end else begin
            tsh_d = {1'b1, tsh_q[9:1]};
            tnb_d = tnb_q - 4'h1;
            tbc_d = 16'(BIT_CYC - 1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tsh_q <= 10'h3FF;
         tnb_q <= 4'h0;
         tbc_q <= 16'h0000;
      end else begin
         tsh_q <= tsh_d;
         tnb_q <= tnb_d;
         tbc_q <= tbc_d;
      end
   end

   assign txd = tsh_q[0];

   // ****************************************
   // Command parser and register state
   // ****************************************
   sai_pst_t ps_q, ps_d;
   logic [3:0] pidx_q, pidx_d;
   logic [6:0] pon_q, pon_d, poff_q, poff_d;
   logic [2:0] plang_q, plang_d;
   logic [4:0] ppos_q, ppos_d;
   logic [1:0] rsel_q, rsel_d;
   logic prog_q, prog_d, tload_q;
   logic [2:0] lang_q, lang_d;
   logic [3:0] tsi_q, tsi_d;
   logic [4:0] tsp_q, tsp_d;
   logic [11:0] mask_q, mask_d, stat_q, stat_d, ev;
   logic cfg_ev, twr;
   logic [10:0] twa, tra;
   logic [31:0] rdata_d, rdata_q;
   logic irq_d, irq_q;
   logic [7:0] txt_mem [`SAI_TXT_WORDS];
   logic wcfg, rd_txt;
   logic [3:0] wsel;

   function automatic logic [10:0] txt_addr(logic [3:0] i,
         logic [2:0] l, logic [4:0] p);
      txt_addr = 11'(i) * 11'h069 + 11'(l) * 11'h015 + 11'(p);
   endfunction

   function automatic logic [6:0] clamp(logic [6:0] v);
      clamp = (v > `SAI_DLY_MAX) ? `SAI_DLY_MAX : v; // RL3 RL4
   endfunction

   assign wcfg = wr && (addr < `SAI_OFS_CFG_END) && (addr[1:0] == 2'h0);
   assign wsel = addr[5:2];
   assign tbyte = (rsel_q == 2'h0) ? {1'b0, cfg_q[pidx_q].on_dly} :
      (rsel_q == 2'h1) ? {1'b0, cfg_q[pidx_q].off_dly} :
      {1'b0, cfg_q[pidx_q].display, cfg_q[pidx_q].nc,
       cfg_q[pidx_q].still, cfg_q[pidx_q].block};
   assign twa = txt_addr(pidx_q, plang_q, ppos_q);
   assign tra = txt_addr(tsi_q, lang_q, tsp_q); // RL10

   always_comb begin
      ps_d = ps_q;
      pidx_d = pidx_q;
      pon_d = pon_q;
      poff_d = poff_q;
      plang_d = plang_q;
      ppos_d = ppos_q;
      rsel_d = rsel_q;
      cfg_d = cfg_q;
      cfg_ev = 1'b0;
      twr = 1'b0;
      tload = 1'b0;
      if (wcfg) begin
         cfg_d[wsel] = sai_cfg_t'(wdata[20:0]);
         cfg_d[wsel].on_dly = clamp(wdata[6:0]);
         cfg_d[wsel].off_dly = clamp(wdata[13:7]);
      end
      if (!prog_q) begin
         ps_d = P_IDLE; // RL11 RL14
      end else if (ps_q == P_READ) begin
         if (tnb_q == 4'h0 && !tload_q) begin
            tload = 1'b1; // RL12
            rsel_d = (rsel_q == 2'h2) ? 2'h0 : rsel_q + 2'h1;
            if (rsel_q == 2'h2) begin
               pidx_d = pidx_q + 4'h1;
               if (pidx_q == 4'hA) begin
                  ps_d = P_IDLE;
               end
            end
         end
      end else if (rvld_q) begin // RL11
         case (ps_q)
            P_IDLE: begin
               if (rsh_q == `SAI_CMD_WR) begin
                  ps_d = P_WIDX;
               end else if (rsh_q == `SAI_CMD_TXT) begin
                  ps_d = P_TIDX;
               end else if (rsh_q == `SAI_CMD_RD) begin
                  ps_d = P_READ;
                  pidx_d = 4'h0;
                  rsel_d = 2'h0;
               end
            end
            P_WIDX: begin
               pidx_d = rsh_q[3:0];
               ps_d = P_WON;
            end
            P_WON: begin
               pon_d = clamp(rsh_q[6:0]);
               ps_d = P_WOFF;
            end
            P_WOFF: begin
               poff_d = clamp(rsh_q[6:0]);
               ps_d = P_WFLG;
            end
            P_WFLG: begin
               if (pidx_q < 4'hB) begin
                  cfg_d[pidx_q] = {rsh_q[6:0], poff_q, pon_q};
                  cfg_ev = 1'b1;
               end
               ps_d = P_IDLE;
            end
            P_TIDX: begin
               pidx_d = rsh_q[3:0];
               ps_d = P_TLANG;
            end
            P_TLANG: begin
               plang_d = rsh_q[2:0];
               ps_d = P_TPOS;
            end
            P_TPOS: begin
               ppos_d = rsh_q[4:0];
               ps_d = P_TCHR;
            end
            P_TCHR: begin
               twr = (pidx_q < 4'hB) && (plang_q < `SAI_NUM_LANG) &&
                  (ppos_q < `SAI_TXT_LEN); // RL10
               ps_d = P_IDLE;
            end
            default: ps_d = P_IDLE;
         endcase
      end
   end

   logic [10:0] rise;

   // Menu software sets the mode bit on entry and clears it on escape.
   always_comb begin
      prog_d = prog_q;
      lang_d = lang_q;
      tsi_d = tsi_q;
      tsp_d = tsp_q;
      mask_d = mask_q;
      if (wr && addr == `SAI_OFS_CTRL) begin
         prog_d = wdata[`SAI_CTRL_PROG_BIT]; // RL11 RL14
      end
      if (wr && addr == `SAI_OFS_LANG) begin
         lang_d = (wdata[2:0] < `SAI_NUM_LANG) ? wdata[2:0] : 3'h0;
      end
      if (wr && addr == `SAI_OFS_TSEL) begin
         tsi_d = wdata[`SAI_TSEL_IDX_LSB +: 4];
         tsp_d = wdata[4:0];
      end
      if (wr && addr == `SAI_OFS_IRQ_MASK) begin
         mask_d = wdata[11:0];
      end
      rise = alarm_d & ~alarm_q;
      ev = {cfg_ev, rise};
      stat_d = stat_q;
      if (rd && addr == `SAI_OFS_IRQ_STAT) begin
         stat_d = 12'h000;
      end
      // A new event in the clearing read's cycle stays set.
      stat_d = stat_d | ev;
      irq_d = |(stat_d & mask_d);
      rd_txt = rd && addr == `SAI_OFS_TXT;
      rdata_d = 32'h00000000;
      if (rd) begin
         if (addr < `SAI_OFS_CFG_END && addr[1:0] == 2'h0) begin
            rdata_d = {11'h000, cfg_q[wsel]};
         end else if (addr == `SAI_OFS_STATE) begin
            rdata_d[10:0] = act;
            rdata_d[`SAI_ST_PROG_BIT] = prog_q;
            rdata_d[`SAI_ST_ENG_BIT] = eng_s2_q;
         end else if (addr == `SAI_OFS_IRQ_STAT) begin
            rdata_d[11:0] = stat_q;
         end else if (addr == `SAI_OFS_IRQ_MASK) begin
            rdata_d[11:0] = mask_q;
         end else if (addr == `SAI_OFS_CTRL) begin
            rdata_d[`SAI_CTRL_PROG_BIT] = prog_q;
         end else if (addr == `SAI_OFS_LANG) begin
            rdata_d[2:0] = lang_q;
         end else if (addr == `SAI_OFS_TSEL) begin
            rdata_d[`SAI_TSEL_IDX_LSB +: 4] = tsi_q;
            rdata_d[4:0] = tsp_q;
         end else if (rd_txt) begin
            rdata_d[7:0] = txt_mem[tra]; // RL10
         end
      end
   end

   // The text store has no reset; unwritten characters read as unknown.
   always_ff @(posedge clk) begin
      if (twr) begin
         txt_mem[twa] <= rsh_q;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= `SAI_CFG_RST; // RL9
         end
         ps_q <= P_IDLE;
         pidx_q <= 4'h0;
         pon_q <= 7'h00;
         poff_q <= 7'h00;
         plang_q <= 3'h0;
         ppos_q <= 5'h00;
         rsel_q <= 2'h0;
         tload_q <= 1'b0;
         prog_q <= 1'b0;
         lang_q <= `SAI_LANG_RST;
         tsi_q <= 4'h0;
         tsp_q <= 5'h00;
         mask_q <= `SAI_MASK_RST;
         stat_q <= 12'h000;
         irq_q <= 1'b0;
         rdata_q <= 32'h00000000;
         alarm_q <= 11'h000;
         ind_q <= 11'h000;
      end else begin
         cfg_q <= cfg_d;
         ps_q <= ps_d;
         pidx_q <= pidx_d;
         pon_q <= pon_d;
         poff_q <= poff_d;
         plang_q <= plang_d;
         ppos_q <= ppos_d;
         rsel_q <= rsel_d;
         tload_q <= tload;
         prog_q <= prog_d;
         lang_q <= lang_d;
         tsi_q <= tsi_d;
         tsp_q <= tsp_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
         alarm_q <= alarm_d;
         ind_q <= ind_d;
      end
   end

   assign rdata = rdata_q;
   assign alarm = alarm_q;
   assign indication = ind_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// *** bench/sai_monitor.sv ***
// Port-level assertions for the ship alarm input conditioner.
`include "sai_params.svh"
`default_nettype none
module sai_monitor #(
   parameter int unsigned BIT_CYC = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [10:0] contact,
   input wire logic txd,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [10:0] alarm,
   input wire logic [10:0] indication,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dirty_q, prog_q;
   logic [11:0] mask_q;
   logic [7:0] low_q, off_q;
   // ****************************************
   // Shadow state
   // ****************************************
   // Any write may change the settings, so default checks stop at the first.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dirty_q <= 1'b0;
         prog_q <= 1'b0;
         mask_q <= 12'h000;
         low_q <= 8'h00;
         off_q <= 8'h00;
      end else begin
         dirty_q <= dirty_q | wr;
         prog_q <= (wr && addr == `SAI_OFS_CTRL) ? wdata[0] : prog_q;
         mask_q <= (wr && addr == `SAI_OFS_IRQ_MASK) ? wdata[11:0] : mask_q;
         low_q <= txd ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
         off_q <= prog_q ? 8'h00 : off_q + {7'h00, off_q != 8'hFF};
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking mcb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_start;
      $fell(txd);
   endsequence
   // The count is one bit time less one, for the bench's bit time of 8.
   sequence s_start_hold;
      !txd [*7];
   endsequence
   start_bit_a: assert property (s_start |=> s_start_hold)
      else $error("start bit shorter than one bit time");
   frame_len_a: assert property (low_q <= 8'(9 * BIT_CYC))
      else $error("transmit line low longer than one frame");
   txd_quiet_a: assert property (off_q > 8'(10 * BIT_CYC + 4) |-> txd)
      else $error("serial output active outside programming mode");
   rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   role_excl_a: assert property ((alarm & indication) == 11'h000)
      else $error("input shown as alarm and indication at once");
   default_role_a: assert property (!dirty_q |-> indication == 11'h000)
      else $error("indication before any configuration");
   irq_mask_a: assert property (
      mask_q == 12'h000 && $past(mask_q) == 12'h000 |-> !irq)
      else $error("interrupt raised while fully masked");
   for (genvar i = 0; i < 11; i++) begin : g_in
      on_delay_a: assert property (!dirty_q && $rose(alarm[i])
         |-> $past(contact[i], 5) && $past(contact[i], 30))
         else $error("alarm rose without a held contact");
      off_delay_a: assert property (!dirty_q && $fell(alarm[i])
         |-> !$past(contact[i], 5) && !$past(contact[i], 30))
         else $error("alarm fell without a held release");
   end
endmodule
`default_nettype wire

// *** bench/sai_pc_model.sv ***
// PC side of the configuration link: sends bytes and collects readback.
`default_nettype none
module sai_pc_model #(
   parameter int unsigned BIT_CYC = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];
   initial rxd = 1'b1;
   // Callers only send after enabling programming mode, unless a refusal
   // is the point of the scenario.
   task automatic send_byte(input logic [7:0] b, input int gap);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      repeat (gap) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         rxd <= fr[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask
   // Bits are taken mid-cell, least significant first.
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = txd;
         end
         got_q.push_back(b);
      end
   end
endmodule
`default_nettype wire

// *** bench/sai_top_bench.sv ***
// Self-checking bench for the ship alarm input conditioner.
`include "sai_params.svh"
`default_nettype none
`define SAI_CHK(g, e) chk((g), (e))
module sai_top_bench
   import sai_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // A short tick and bit time keep the run brief; waits derive from them.
   localparam int unsigned TICK = 20;
   localparam int unsigned BITC = 8;
   typedef struct packed {
      logic [2:0] f;
      logic [3:0] blk;
      logic [10:0] con;
      logic eng;
      logic [10:0] ea;
      logic [10:0] ei;
   } sai_row_t;
   logic clk, resetn, engine_run, rxd, txd, wr, rd, irq;
   logic [10:0] contact, alarm, indication;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   int err_count = 0, n_checks = 0, cyc = 0, k;
   sai_row_t rows[10] = '{
      '{3'b000, 4'h0, 11'h001, 1'b1, 11'h001, 11'h000},
      '{3'b010, 4'h0, 11'h000, 1'b1, 11'h001, 11'h000},
      '{3'b010, 4'h0, 11'h001, 1'b1, 11'h000, 11'h000},
      '{3'b100, 4'h0, 11'h001, 1'b1, 11'h000, 11'h001},
      '{3'b001, 4'h0, 11'h001, 1'b0, 11'h000, 11'h000},
      '{3'b001, 4'h0, 11'h001, 1'b1, 11'h001, 11'h000},
      '{3'b000, 4'h2, 11'h003, 1'b1, 11'h002, 11'h000},
      '{3'b000, 4'h0, 11'h003, 1'b1, 11'h003, 11'h000},
      '{3'b000, 4'h1, 11'h003, 1'b1, 11'h003, 11'h000},
      '{3'b000, 4'hC, 11'h003, 1'b1, 11'h003, 11'h000}};
   sai_top #(.TICK_CYC(TICK), .BIT_CYC(BITC)) sai_top_i (
      .clk(clk), .resetn(resetn), .contact(contact),
      .engine_run(engine_run), .rxd(rxd), .txd(txd), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm(alarm),
      .indication(indication), .irq(irq));
   sai_pc_model #(.BIT_CYC(BITC)) sai_pc_model_i (
      .clk(clk), .resetn(resetn), .txd(txd), .rxd(rxd));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // The parser acts on the last byte only after its stop sample.
   task automatic send(input logic [7:0] q[$]);
      foreach (q[j]) sai_pc_model_i.send_byte(q[j], j);
      repeat (2 * BITC) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      resetn = 1'b0;
      contact = 11'h000;
      engine_run = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd_reg(8'(4 * i));
         `SAI_CHK(d, 32'h00000183);
      end
      @(posedge clk);
      contact <= 11'h008;
      repeat (30) @(posedge clk);
      contact <= 11'h000;
      repeat (5) @(posedge clk);
      contact <= 11'h008;
      look(2 * TICK - 5);
      `SAI_CHK(alarm, 11'h000);
      look(TICK + 40);
      `SAI_CHK(alarm, 11'h008);
      @(posedge clk);
      contact <= 11'h000;
      look(2 * TICK - 5);
      `SAI_CHK(alarm, 11'h008);
      look(TICK + 40);
      `SAI_CHK(alarm, 11'h000);
      foreach (rows[r]) begin
         wr_reg(`SAI_OFS_CFG0, {11'h000, rows[r].f, rows[r].blk, 14'h0000});
         contact <= rows[r].con;
         engine_run <= rows[r].eng;
         look(4 * TICK + 10);
         `SAI_CHK(alarm, rows[r].ea);
         `SAI_CHK(indication, rows[r].ei);
      end
      wr_reg(8'h04, 32'h00003C78);
      rd_reg(8'h04);
      `SAI_CHK(d, 32'h000031E3);
      rd_reg(8'h30);
      `SAI_CHK(d, 32'h0);
      rd_reg(`SAI_OFS_IRQ_STAT);
      send({8'h57, 8'h00, 8'h05, 8'h02, 8'h00});
      rd_reg(`SAI_OFS_CFG0);
      `SAI_CHK(d, 32'h00030000);
      wr_reg(`SAI_OFS_CTRL, 32'h1);
      rd_reg(`SAI_OFS_STATE);
      `SAI_CHK(d[16], 1'b1);
      send({8'h57, 8'h00, 8'h05, 8'h02, 8'h00});
      look(4);
      `SAI_CHK(irq, 1'b0);
      rd_reg(`SAI_OFS_CFG0);
      `SAI_CHK(d, 32'h00000105);
      wr_reg(`SAI_OFS_IRQ_MASK, 32'h00000800);
      look(3);
      `SAI_CHK(irq, 1'b1);
      rd_reg(`SAI_OFS_IRQ_STAT);
      `SAI_CHK(d[11], 1'b1);
      look(2);
      `SAI_CHK(irq, 1'b0);
      send({8'h54, 8'h00, 8'h01, 8'h00, 8'h41});
      wr_reg(`SAI_OFS_LANG, 32'h1);
      wr_reg(`SAI_OFS_TSEL, 32'h0);
      rd_reg(`SAI_OFS_TXT);
      `SAI_CHK(d, 32'h00000041);
      wr_reg(`SAI_OFS_LANG, 32'h7);
      rd_reg(`SAI_OFS_LANG);
      `SAI_CHK(d, 32'h0);
      send({8'h52});
      for (k = 0; k < 4000 && sai_pc_model_i.got_q.size() < 33; k++)
         @(posedge clk);
      look(4 * BITC);
      `SAI_CHK(sai_pc_model_i.got_q.size(), 33);
      `SAI_CHK({sai_pc_model_i.got_q[0], sai_pc_model_i.got_q[1]}, 16'h0502);
      `SAI_CHK({sai_pc_model_i.got_q[3], sai_pc_model_i.got_q[30]}, 16'h6303);
      wr_reg(`SAI_OFS_CTRL, 32'h0);
      rd_reg(`SAI_OFS_STATE);
      `SAI_CHK(d[16], 1'b0);
      send({8'h57, 8'h00, 8'h09, 8'h09, 8'h00});
      rd_reg(`SAI_OFS_CFG0);
      `SAI_CHK(d, 32'h00000105);
      report_and_stop();
   end
endmodule
bind sai_top sai_monitor #(.BIT_CYC(BIT_CYC)) sai_monitor_i (
   .clk(clk), .resetn(resetn), .contact(contact), .txd(txd),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .alarm(alarm), .indication(indication), .irq(irq));
`default_nettype wire
